// File: logic/ks_map_pkg.sv
// Constants and types shared by the key stream segment mapper
package ks_map_pkg;

   // ----------------------------------------------------------------
   // Field geometry
   // ----------------------------------------------------------------
   localparam int unsigned TAIL_BITS      = 40;   // Enciphered A-field tail length
   localparam int unsigned SUB_LEN        = 80;   // Protected subfield: data plus check
   localparam int unsigned SUB_DATA       = 64;   // Data part of a protected subfield
   localparam int unsigned DOUBLE_SEG_LEN = 840;  // Double slot segment length
   localparam int unsigned DOUBLE_B_BITS  = 800;  // Double slot B-field data bits
   localparam int unsigned SINGLE_DATA    = 768;  // Single subfield data before 32-bit check
   localparam int unsigned SINGLE_CHECK   = 32;   // Single subfield check length
   localparam int unsigned RATIO_ONE      = 256;  // Codec ratio scale: 9'h100 means r = 1

   // ----------------------------------------------------------------
   // Register map (byte addresses) and reset values
   // ----------------------------------------------------------------
   localparam logic [3:0]  CTRL_ADDR   = 4'h0;
   localparam logic [3:0]  STATUS_ADDR = 4'h4;
   localparam logic [3:0]  PAIRS_ADDR  = 4'h8;
   localparam int unsigned CTRL_ENABLE = 0;       // Cipher enable bit
   localparam int unsigned CTRL_CLR    = 1;       // Write one: clear pair counter
   localparam logic        ENABLE_RST  = 1'b0;
   localparam logic [15:0] PAIRS_RST   = 16'h0000;

   // ----------------------------------------------------------------
   // B-field formats
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FMT_UNPROT,    // unprotected_double_mapping and its half/long form
      FMT_MULTI,     // multi_subfield_u_mapping or multi_subfield_e_mapping
      FMT_SINGLE,    // single_subfield_mapping, double slot only
      FMT_ENCODED    // encoded_protected_service
   } bformat_e;

endpackage : ks_map_pkg

// File: logic/ks_bit_select.sv
// Per-bit decision: whether a segment bit is applied and a field bit consumed
`timescale 1ns/10ps
module ks_bit_select
   import ks_map_pkg::*;
(
   // Position in the segment
   input  wire logic           in_tail_i,
   input  wire logic [9:0]     b_index_i,
   input  wire logic [6:0]     sub_pos_i,
   input  wire logic [3:0]     sub_blk_i,
   // Field pair configuration
   input  wire bformat_e       bformat_i,
   input  wire logic           tail_ct_i,
   input  wire logic [3:0]     full_blocks_i,
   input  wire logic [9:0]     used_bits_i,
   // Decision
   output logic                apply_o,
   output logic                consume_o
);

   // Encoded service only carries the payload bits, the rest of the key is dropped
   always_comb
   begin
      consume_o = 1'b1;
      apply_o   = 1'b0;
      if (in_tail_i)
      begin
         apply_o = tail_ct_i;                                       // R2
      end
      else
      begin
         unique case (bformat_i)
            FMT_UNPROT:
            begin
               apply_o = 1'b1;                                      // R5 R12
            end
            FMT_MULTI:
            begin
               // Check bits and padding pass in clear, key bits still used up
               apply_o = (sub_pos_i < 7'(SUB_DATA))                 // R4 R6 R15
                         && (sub_blk_i < full_blocks_i);            // R8
            end
            FMT_SINGLE:
            begin
               apply_o = (b_index_i < 10'(SINGLE_DATA));            // R13 R14
            end
            FMT_ENCODED:
            begin
               apply_o   = (b_index_i < used_bits_i);               // R9 R16
               consume_o = (b_index_i < used_bits_i);
            end
         endcase
      end
   end

endmodule : ks_bit_select

// File: logic/slot_keystream_xor_mapper.sv
// Key stream segment mapper: XORs key bits onto tail and B-field bits
// Function
// R1: Half/long slot: two segments of 40+j bits
// R2: Control tail: XOR key 0..39 onto a8..a47
// R3: Only tail and B data pass; header clear
// R4: Check bit positions consume key, stay clear
// R5: Unprotected half/long B: key 40+ onto b0..
// R6: Multi protected: 64 of each 80 enciphered
// R7: E-type multiplex handled as multi protected
// R8: Padding bits clear, key still consumed
// R9: Encoded half/long: first j*r bits enciphered
// R10: Half/long pair totals 80+2j bits
// R11: Double slot: two 840-bit segments
// R12: Double unprotected: key 40..839 onto b0..799
// R13: Double single protected: 768 enciphered, 32 clear
// R14: Single protected holds 768 data, 32 check
// R15: Double multi: ten subfields, 64 data each
// R16: Double encoded: first 800*r bits enciphered
// R17: Double slot pair totals 1680 bits
// R18: First then second segment per frame
// R19: Framing gives j, format, tail, r first
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
module slot_keystream_xor_mapper
   import ks_map_pkg::*;
#(
   parameter int unsigned JMAX = 800               // Largest half/long B length served
)
(
   // Clock and reset
   input  wire logic           clk_i,
   input  wire logic           rst_i,
   // Wishbone register slave
   input  wire logic           wb_cyc_i,
   input  wire logic           wb_stb_i,
   input  wire logic           wb_we_i,
   input  wire logic [3:0]     wb_adr_i,
   input  wire logic [3:0]     wb_sel_i,
   input  wire logic [31:0]    wb_dat_i,
   output logic [31:0]         wb_dat_o,
   output logic                wb_ack_o,
   // Field pair setup from framing
   input  wire logic           start_i,
   input  wire logic           double_slot_i,
   input  wire bformat_e       bformat_i,
   input  wire logic           tail_ct_i,
   input  wire logic [9:0]     j_i,
   input  wire logic [8:0]     ratio_i,
   output logic                busy_o,
   output logic                pair_done_o,
   // Key stream bits from the generator
   input  wire logic           ks_valid_i,
   input  wire logic           ks_bit_i,
   output logic                ks_ready_o,
   // Clear field bits from framing (tail then B data)
   input  wire logic           fld_valid_i,
   input  wire logic           fld_bit_i,
   output logic                fld_ready_o,
   // Processed field bits to coding
   output logic                out_valid_o,
   output logic                out_bit_o,
   input  wire logic           out_ready_i,
   output logic                out_second_o
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (JMAX < SUB_LEN || JMAX > 1023 - TAIL_BITS)
   begin : g_bad_jmax
      $error("JMAX out of range for the 10-bit segment index");
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   typedef enum {ST_IDLE, ST_RUN} state_e;

   state_e        state;
   bformat_e      fmt;
   logic          tail_ct;
   logic [9:0]    seg_last;      // Last key index of a segment
   logic [3:0]    full_blocks;   // Whole protected subfields in B
   logic [9:0]    used_bits;     // Enciphered payload bits, encoded service
   logic [9:0]    k_index;       // Key bit index within segment
   logic          second_seg;
   logic [6:0]    sub_pos;
   logic [3:0]    sub_blk;
   logic          enable;
   logic [15:0]   pairs;
   logic          apply;
   logic          consume;
   logic          in_tail;
   logic [9:0]    b_index;
   logic          out_free;
   logic          step;
   logic          last_bit;
   logic [9:0]    b_len;
   logic [18:0]   used_prod;
   logic          wb_req;

   // ----------------------------------------------------------------
   // Setup arithmetic
   // ----------------------------------------------------------------
   // B length and enciphered payload for the incoming configuration;
   // a j above JMAX is clipped, since the counters cannot reach further
   always_comb
   begin
      b_len = j_i;
      if (j_i > 10'(JMAX))
      begin
         b_len = 10'(JMAX);
      end
      if (double_slot_i)
      begin
         b_len = 10'(DOUBLE_B_BITS);
      end
      used_prod = 19'(b_len) * 19'(ratio_i);                        // R9 R16
   end

   // ----------------------------------------------------------------
   // Bit selection
   // ----------------------------------------------------------------
   assign in_tail = (k_index < 10'(TAIL_BITS));
   assign b_index = k_index - 10'(TAIL_BITS);

   ks_bit_select u_select (
      .in_tail_i     (in_tail),
      .b_index_i     (b_index),
      .sub_pos_i     (sub_pos),
      .sub_blk_i     (sub_blk),
      .bformat_i     (fmt),
      .tail_ct_i     (tail_ct),
      .full_blocks_i (full_blocks),
      .used_bits_i   (used_bits),
      .apply_o       (apply),
      .consume_o     (consume)
   );

   // ----------------------------------------------------------------
   // Handshakes
   // ----------------------------------------------------------------
   // A key bit moves only when its field bit (if any) and output room exist
   assign out_free    = !out_valid_o || out_ready_i;
   assign step        = (state == ST_RUN) && ks_valid_i
                        && (!consume || (fld_valid_i && out_free));
   assign ks_ready_o  = (state == ST_RUN) && (!consume || (fld_valid_i && out_free));
   assign fld_ready_o = (state == ST_RUN) && consume && ks_valid_i && out_free;
   assign last_bit    = step && (k_index == seg_last) && second_seg;
   assign busy_o      = (state == ST_RUN);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // Config is latched once per pair; framing must hold it valid at start
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state       <= ST_IDLE;
         fmt         <= FMT_UNPROT;
         tail_ct     <= 1'b0;
         seg_last    <= 10'h000;
         full_blocks <= 4'h0;
         used_bits   <= 10'h000;
      end
      else
      begin
         unique case (state)
            ST_IDLE:
            begin
               if (start_i)                                         // R19
               begin
                  state       <= ST_RUN;
                  // Single subfield only exists on double slots; fall back to multi
                  fmt         <= (bformat_i == FMT_SINGLE && !double_slot_i)
                                 ? FMT_MULTI : bformat_i;           // R7
                  tail_ct     <= tail_ct_i;
                  seg_last    <= 10'(TAIL_BITS) + b_len - 10'h001;  // R1 R10 R11 R17
                  full_blocks <= 4'(b_len / 10'(SUB_LEN));          // R8 R15
                  used_bits   <= used_prod[17:8];
                  if (used_prod[18])
                  begin
                     used_bits <= b_len;
                  end
               end
            end
            ST_RUN:
            begin
               if (last_bit)
               begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Segment index and subfield position; header, RA and X never enter here
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         k_index    <= 10'h000;
         second_seg <= 1'b0;
         sub_pos    <= 7'h00;
         sub_blk    <= 4'h0;
      end
      else if (state == ST_IDLE)
      begin
         k_index    <= 10'h000;
         second_seg <= 1'b0;
         sub_pos    <= 7'h00;
         sub_blk    <= 4'h0;
      end
      else if (step)                                                // R3
      begin
         if (k_index == seg_last)
         begin
            k_index    <= 10'h000;
            second_seg <= 1'b1;                                     // R18
            sub_pos    <= 7'h00;
            sub_blk    <= 4'h0;
         end
         else
         begin
            k_index <= k_index + 10'h001;
            if (!in_tail)
            begin
               if (sub_pos == 7'(SUB_LEN - 1))
               begin
                  sub_pos <= 7'h00;
                  sub_blk <= sub_blk + 4'h1;
               end
               else
               begin
                  sub_pos <= sub_pos + 7'h01;
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Output stage
   // ----------------------------------------------------------------
   // Registered bit keeps the data output glitch free toward the coder
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         out_valid_o  <= 1'b0;
         out_bit_o    <= 1'b0;
         out_second_o <= 1'b0;
      end
      else if (step && consume)
      begin
         out_valid_o  <= 1'b1;
         out_bit_o    <= fld_bit_i ^ (apply & enable & ks_bit_i);   // R2 R5 R6 R12 R13
         out_second_o <= second_seg;
      end
      else if (out_ready_i)
      begin
         out_valid_o <= 1'b0;
      end
   end

   // End of pair pulse
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pair_done_o <= 1'b0;
      end
      else
      begin
         pair_done_o <= last_bit;
      end
   end

   // ----------------------------------------------------------------
   // Register slave
   // ----------------------------------------------------------------
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   // One wait state, ack dropped the cycle after it is given
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= wb_req;
      end
   end

   // Enable steers the XOR; disabled pairs still consume key to stay aligned
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         enable <= ENABLE_RST;
      end
      else if (wb_req && wb_we_i && wb_adr_i == CTRL_ADDR && wb_sel_i[0])
      begin
         enable <= wb_dat_i[CTRL_ENABLE];
      end
   end

   // Pair counter; a finishing pair wins over a software clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pairs <= PAIRS_RST;
      end
      else if (last_bit)
      begin
         pairs <= pairs + 16'h0001;
      end
      else if (wb_req && wb_we_i && wb_adr_i == CTRL_ADDR && wb_sel_i[0]
               && wb_dat_i[CTRL_CLR])
      begin
         pairs <= PAIRS_RST;
      end
   end

   // Read data; unmapped addresses answer with zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_dat_o <= 32'h0000_0000;
      end
      else if (wb_req)
      begin
         unique case (wb_adr_i)
            CTRL_ADDR:   wb_dat_o <= {31'h0000_0000, enable};
            STATUS_ADDR: wb_dat_o <= {6'h00, k_index, 14'h0000, second_seg, busy_o};
            PAIRS_ADDR:  wb_dat_o <= {16'h0000, pairs};
            default:     wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

endmodule : slot_keystream_xor_mapper

// File: dv/slot_keystream_xor_mapper_properties.sv
// Port-level timing checks for the key stream mapper
`timescale 1ns/10ps
module ks_mapper_checker
   import ks_map_pkg::*;
#(
   parameter int unsigned JMAX = 800
)
(
   // Clock, reset and bus
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // Pair control
   input wire logic start_i,
   input wire logic busy_o,
   input wire logic pair_done_o,
   // Streams
   input wire logic ks_valid_i,
   input wire logic ks_ready_o,
   input wire logic fld_valid_i,
   input wire logic fld_ready_o,
   input wire logic out_valid_o,
   input wire logic out_bit_o,
   input wire logic out_ready_i
);
   // One domain, so clock and reset are given once
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_ack_next;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_busy_start;
      start_i && !busy_o |=> busy_o;
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("start not taken");
   property p_done_end;
      pair_done_o |-> !busy_o && $past(busy_o);
   endproperty
   a_done_end: assert property (p_done_end) else $error("done without busy end");
   property p_done_pulse;
      pair_done_o |=> !pair_done_o;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done too long");
   property p_idle_quiet;
      !busy_o |-> !ks_ready_o && !fld_ready_o;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("ready while idle");
   property p_field_with_key;
      fld_valid_i && fld_ready_o |-> ks_valid_i && ks_ready_o;
   endproperty
   a_field_with_key: assert property (p_field_with_key) else $error("field alone");
   property p_out_next;
      ks_valid_i && ks_ready_o && fld_valid_i && fld_ready_o |=> out_valid_o;
   endproperty
   a_out_next: assert property (p_out_next) else $error("no output bit");
   property p_out_hold;
      out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_bit_o);
   endproperty
   a_out_hold: assert property (p_out_hold) else $error("output dropped");
endmodule : ks_mapper_checker

bind slot_keystream_xor_mapper ks_mapper_checker #(.JMAX(JMAX)) u_ks_mapper_checker (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .start_i, .busy_o, .pair_done_o,
   .ks_valid_i, .ks_ready_o, .fld_valid_i, .fld_ready_o, .out_valid_o, .out_bit_o,
   .out_ready_i);

// File: dv/ks_partner_model.sv
// Behavioural key stream generator and clear field source
`timescale 1ns/10ps
module ks_partner_model
(
   // Clock, reset, pacing
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic slow_i,
   // Key and field streams
   output logic      ks_valid_o,
   output logic      ks_bit_o,
   input  wire logic ks_ready_i,
   output logic      fld_valid_o,
   output logic      fld_bit_o,
   input  wire logic fld_ready_i
);
   int kn;
   int fn;
   int seed = 30;
   logic kv;
   logic fv;

   // Bits in index order, held until taken; idle lines toggle, not frozen
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         kn = 0;
         fn = 0;
         ks_valid_o <= 1'b0;
         fld_valid_o <= 1'b0;
         ks_bit_o <= 1'b0;
         fld_bit_o <= 1'b0;
      end
      else
      begin
         kn = kn + (ks_valid_o && ks_ready_i);
         fn = fn + (fld_valid_o && fld_ready_i);
         kv = !slow_i || (ks_valid_o && !ks_ready_i) || $random(seed) % 3 == 0;
         fv = !slow_i || (fld_valid_o && !fld_ready_i) || $random(seed) % 3 == 0;
         ks_valid_o <= kv;
         ks_bit_o <= kv ? kn[0] ^ kn[2] ^ kn[5] ^ kn[8] : ~ks_bit_o;
         fld_valid_o <= fv;
         fld_bit_o <= fv ? fn[1] ^ fn[3] ^ fn[4] ^ fn[9] : ~fld_bit_o;
      end
   end
endmodule : ks_partner_model

// File: dv/slot_keystream_xor_mapper_tb_top.sv
// Self-checking bench for the key stream mapper
`timescale 1ns/10ps
module slot_keystream_xor_mapper_tb_top
   import ks_map_pkg::*;
;
   logic        clk_i, rst_i, start_i, double_slot_i, tail_ct_i, busy_o, pair_done_o;
   logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ks_valid_i, ks_bit_i, ks_ready_o;
   logic        fld_valid_i, fld_bit_i, fld_ready_o, out_valid_o, out_bit_o, out_ready_i;
   logic        out_second_o, slow;
   logic [3:0]  wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [9:0]  j_i;
   logic [8:0]  ratio_i;
   bformat_e    bformat_i;
   logic [1:0]  eq[$];
   int          n_mismatch, n_compared, seed, kn, fn, nks, cyc, pairs, i;

   slot_keystream_xor_mapper u_slot_keystream_xor_mapper (.clk_i, .rst_i, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .start_i,
      .double_slot_i, .bformat_i, .tail_ct_i, .j_i, .ratio_i, .busy_o, .pair_done_o,
      .ks_valid_i, .ks_bit_i, .ks_ready_o, .fld_valid_i, .fld_bit_i, .fld_ready_o,
      .out_valid_o, .out_bit_o, .out_ready_i, .out_second_o);
   ks_partner_model u_ks_partner_model (.clk_i, .rst_i, .slow_i(slow),
      .ks_valid_o(ks_valid_i), .ks_bit_o(ks_bit_i), .ks_ready_i(ks_ready_o),
      .fld_valid_o(fld_valid_i), .fld_bit_o(fld_bit_i), .fld_ready_i(fld_ready_o));

   // 10 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic wrap_up();
      $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up

   // Scoreboard on taken output bits, random back-pressure, hang guard last
   always @(posedge clk_i)
   begin
      out_ready_i <= $random(seed) % 4 != 0;
      nks = nks + (!rst_i && ks_valid_i && ks_ready_o);
      if (!rst_i && out_valid_o && out_ready_i)
         chk({out_second_o, out_bit_o}, eq.size() ? eq.pop_front() : 2'bxx, "bit");
      cyc++;
      if (cyc > 90000)
      begin
         n_mismatch++;
         wrap_up();
      end
   end

   // Classic cycle: hold until ack, release, one idle cycle
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int t;
      t = 0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
      do
      begin
         @(posedge clk_i);
         t++;
      end
      while (wb_ack_o !== 1'b1 && t < 50);
      chk(wb_ack_o, 1'b1, "ack");
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge clk_i);
   endtask : wb

   // Model one pair from the mapping rules, then run it
   task automatic run(input logic d, input bformat_e f, input logic t, input int j, r,
                      input logic en);
      int ln, bl, b, s, k;
      logic ap, co, kb;
      ln = d ? 840 : 40 + j;
      bl = d ? 800 : j;
      for (s = 0; s < 2; s++)
         for (k = 0; k < ln; k++)
         begin
            b = k - 40;
            co = f != FMT_ENCODED || b < bl * r / 256;
            ap = k < 40 ? t : f == FMT_UNPROT || (f == FMT_ENCODED ? co :
                 f == FMT_SINGLE && d ? b < 768 : b % 80 < 64 && b / 80 < bl / 80);
            kb = kn[0] ^ kn[2] ^ kn[5] ^ kn[8];
            kn++;
            if (co)
               eq.push_back({s[0], fn[1] ^ fn[3] ^ fn[4] ^ fn[9] ^ (ap & en & kb)});
            fn = fn + co;
         end
      nks = 0;
      slow <= pairs[0];
      {start_i, double_slot_i, tail_ct_i, j_i, ratio_i} <= {1'b1, d, t, j[9:0], r[8:0]};
      bformat_i <= f;
      @(posedge clk_i);
      start_i <= 1'b0;
      k = 0;
      while (pair_done_o !== 1'b1 && k++ < 9000)
         @(posedge clk_i);
      chk(nks, 2 * ln, "key count");
      repeat (30) @(posedge clk_i);
      chk(eq.size(), 0, "bits left");
      pairs++;
   endtask : run

   // Reset, registers, every format on both slot kinds, random pairs
   initial
   begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, start_i, double_slot_i, tail_ct_i, slow} = '1;
      {wb_cyc_i, wb_stb_i, wb_we_i, start_i, double_slot_i, tail_ct_i, slow} = '0;
      {wb_adr_i, wb_sel_i, wb_dat_i, j_i, ratio_i} = {4'h0, 4'hf, 32'h0, 10'h050, 9'h100};
      bformat_i = FMT_UNPROT;
      {out_ready_i, seed} = {1'b1, 32'd30};
      {n_mismatch, n_compared, kn, fn, nks, cyc, pairs} = '0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, CTRL_ADDR, 32'h0);
      chk(rd[0], ENABLE_RST, "enable reset");
      wb(1'b1, 4'hc, $random(seed));
      wb(1'b0, 4'hc, 32'h0);
      chk(rd, 32'h0, "unmapped");
      wb(1'b1, CTRL_ADDR, {$random(seed)} & 32'hfffffffd | 32'h1);
      wb(1'b0, CTRL_ADDR, 32'h0);
      chk(rd[0], 1'b1, "enable");
      run(0, FMT_UNPROT, 1, 80, 256, 1);
      run(0, FMT_MULTI, 0, 672, 256, 1);
      run(0, FMT_SINGLE, 1, 160, 256, 1);
      run(0, FMT_ENCODED, 1, 320, 192, 1);
      run(1, FMT_UNPROT, 0, 800, 256, 1);
      run(1, FMT_MULTI, 1, 800, 256, 1);
      run(1, FMT_SINGLE, 1, 800, 256, 1);
      run(1, FMT_ENCODED, 0, 800, 128, 1);
      for (i = 0; i < 3; i++)
         run(0, bformat_e'(2'($random(seed))), $random(seed), 80 + {$random(seed)} % 721,
             1 + {$random(seed)} % 256, 1);
      wb(1'b0, PAIRS_ADDR, 32'h0);
      chk(rd[15:0], pairs, "pairs");
      wb(1'b1, CTRL_ADDR, 32'h2);
      wb(1'b0, PAIRS_ADDR, 32'h0);
      chk(rd[15:0], 16'h0, "pairs cleared");
      run(0, FMT_UNPROT, 1, 80, 256, 0);
      wb(1'b0, PAIRS_ADDR, 32'h0);
      chk(rd[15:0], 16'h1, "pairs after clear");
      wb(1'b0, STATUS_ADDR, 32'h0);
      chk(rd, 32'h0, "status idle");
      wrap_up();
   end
endmodule : slot_keystream_xor_mapper_tb_top
